// ==== rtl/fhs_status_rate.sv ====
// Purpose: Main status and data-rate select logic at one shared I/O offset
// Assumes: Host strobes and controller events synchronous to sys_clk
// Notes:   FIFO and command engine live outside; they report events here
// Notes on behaviour
// - Status reads zero until oscillator settles and internal state initialises.
// - After any reset status shows 80h within 2.5 us.
// - DMA execution, or DMA result waiting, shows request and busy only.
// - Non-DMA wait for host to read result bytes shows request, direction and busy.
// - Request bit clears after each byte, sets when next byte possible.
// - Non-DMA execution request bit follows the interrupt line.
// - Direction bit one means host reads, zero means host writes.
// - Non-DMA execution sets bit 5 throughout execution.
// - Busy sets on first command byte, clears on last result byte.
// - Commands without results clear busy after last command byte.
// - Bits 3 and 2 read zero in a two-drive system.
// - Drive 1 seek bit sets on seek issue, clears on sense read.
// - Drive 0 seek bit sets on seek issue, clears on sense read.
// - Write-only rate select shares the offset and resets to 02h.
// - Data rate rescales drive control timing.
// - Oscillator powerdown bit stops oscillator; clear keeps it running.
// - Hardware reset clears oscillator powerdown; software resets leave it.
// - Oscillator powerdown never gates the crystal clock input.
// - Save reports oscillator powerdown; restore never sets it to one.
// - Rate and precompensation fields survive software resets.
// - Rate-select bit 7 is a self-clearing software reset.
// - Rate-select bit 6 resets and powers down the module until reset.
// - Bits 4 to 2 select precompensation, 000 the default.
`timescale 1ns/1ps
`include "fhs_consts.svh"

module fhs_status_rate #(
  parameter int INIT_CYCLES = `FHS_INIT_CYCLES
) (
  // Clock and reset
  input  wire logic           sys_clk,
  input  wire logic           reset_n,
  // Host I/O port
  input  wire logic [3:0]     io_addr,
  input  wire logic           io_rd,
  input  wire logic           io_wr,
  input  wire logic [7:0]     io_wdata,
  output logic      [7:0]     io_rdata,
  // Controller events
  input  wire fhs_pkg::fhs_ctl_t ctl,
  // Status and settings out
  output logic      [7:0]     main_status_reg,
  output logic      [1:0]     data_rate_field,
  output logic      [2:0]     write_field_a,
  output logic                oscillator_powerdown,
  output logic                osc_enable,
  output logic                direct_powerdown,
  output logic                module_soft_reset,
  output logic                rate_tick
);

  // ****************************************
  // Host decode and reset sources
  // ****************************************
  logic sel;
  logic wr_hit;
  logic soft_rst;
  assign sel    = (io_addr == `FHS_OFS_STATUS_RATE);
  assign wr_hit = sel && io_wr;
  assign soft_rst = ctl.dor_reset || (wr_hit && io_wdata[`FHS_RS_SWRST]);

  function automatic logic [9:0] bit_cycles(input logic [1:0] rate);
    unique case (rate)
      2'h0: bit_cycles = `FHS_BIT_500K;
      2'h1: bit_cycles = `FHS_BIT_300K;
      2'h2: bit_cycles = `FHS_BIT_250K;
      2'h3: bit_cycles = `FHS_BIT_1M;
    endcase
  endfunction

  // ****************************************
  // Rate-select register
  // ****************************************
  logic [1:0] rate_r;
  logic [1:0] rate_nxt;
  logic [2:0] pre_r;
  logic [2:0] pre_nxt;
  logic       oscillator_powerdown_r;
  logic       oscillator_powerdown_nxt;
  logic       fpd_r;
  logic       fpd_nxt;
  logic       srst_r;
  logic       srst_nxt;
  localparam logic [7:0] RATE_RST = `FHS_RATE_RESET;

  always_comb begin
    rate_nxt  = rate_r;
    pre_nxt   = pre_r;
    oscillator_powerdown_nxt = oscillator_powerdown_r;
    fpd_nxt   = fpd_r;
    srst_nxt  = soft_rst;
    if (soft_rst) begin
      fpd_nxt = 1'b0;
    end
    if (wr_hit) begin
      rate_nxt  = io_wdata[`FHS_RS_RATE_HI:`FHS_RS_RATE_LO];
      pre_nxt   = io_wdata[`FHS_RS_PRE_HI:`FHS_RS_PRE_LO];
      oscillator_powerdown_nxt = io_wdata[`FHS_RS_OSCILLATOR_POWERDOWN];
      if (io_wdata[`FHS_RS_FPD]) begin
        fpd_nxt = 1'b1;
      end
    end else if (ctl.restore_wr && !ctl.restore_oscillator_powerdown) begin
      oscillator_powerdown_nxt = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rate_r  <= RATE_RST[`FHS_RS_RATE_HI:`FHS_RS_RATE_LO];
      pre_r   <= `FHS_WRITE_FIELD_A_DEFAULT;
      oscillator_powerdown_r <= 1'b0;
      fpd_r   <= 1'b0;
      srst_r  <= 1'b0;
    end else begin
      rate_r  <= rate_nxt;
      pre_r   <= pre_nxt;
      oscillator_powerdown_r <= oscillator_powerdown_nxt;
      fpd_r   <= fpd_nxt;
      srst_r  <= srst_nxt;
    end
  end

  assign data_rate_field      = rate_r;
  assign write_field_a        = pre_r;
  assign oscillator_powerdown = oscillator_powerdown_r;
  assign osc_enable           = !oscillator_powerdown_r;
  assign direct_powerdown     = fpd_r;
  assign module_soft_reset    = srst_r;

  // ****************************************
  // Drive timing tick scaled by data rate
  // ****************************************
  logic [9:0] tick_cnt_r;
  logic [9:0] tick_cnt_nxt;
  logic       tick_r;
  logic       tick_nxt;

  always_comb begin
    tick_nxt = 1'b0;
    if (tick_cnt_r + 10'h001 >= bit_cycles(rate_r)) begin
      tick_cnt_nxt = 10'h000;
      tick_nxt     = 1'b1;
    end else begin
      tick_cnt_nxt = tick_cnt_r + 10'h001;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tick_cnt_r <= 10'h000;
      tick_r     <= 1'b0;
    end else begin
      tick_cnt_r <= tick_cnt_nxt;
      tick_r     <= tick_nxt;
    end
  end

  assign rate_tick = tick_r;

  // ****************************************
  // Command phase tracking
  // ****************************************
  fhs_pkg::fhs_phase_t ph_r;
  fhs_pkg::fhs_phase_t ph_nxt;
  logic [15:0] init_r;
  logic [15:0] init_nxt;
  logic        rqm_r;
  logic        rqm_nxt;
  logic [1:0]  seek_r;
  logic [1:0]  seek_nxt;
  logic [7:0]  stat_nxt;

  always_comb begin
    ph_nxt   = ph_r;
    init_nxt = init_r;
    rqm_nxt  = rqm_r;
    seek_nxt = seek_r;
    if (ctl.fifo_xfer) begin
      rqm_nxt = 1'b0;
    end
    if (ctl.byte_ready) begin
      rqm_nxt = 1'b1;
    end
    if (ctl.sense_first) begin
      seek_nxt[ctl.sense_drive] = 1'b0;
    end
    unique case (ph_r)
      fhs_pkg::FHS_INIT: begin
        rqm_nxt = 1'b1;
        if (!fpd_r) begin
          if (init_r + 16'h0001 >= 16'(INIT_CYCLES)) begin
            ph_nxt = fhs_pkg::FHS_IDLE;
          end else begin
            init_nxt = init_r + 16'h0001;
          end
        end
      end
      fhs_pkg::FHS_IDLE, fhs_pkg::FHS_CMD: begin
        if (ph_r == fhs_pkg::FHS_IDLE && ctl.fifo_xfer) begin
          ph_nxt = fhs_pkg::FHS_CMD;
        end
        if (ctl.cmd_done) begin
          if (ctl.seek_cmd) begin
            seek_nxt[ctl.cmd_drive] = 1'b1;
          end
          ph_nxt  = ctl.no_result ? fhs_pkg::FHS_IDLE : fhs_pkg::FHS_EXEC;
          rqm_nxt = ctl.no_result;
        end
      end
      fhs_pkg::FHS_EXEC: begin
        if (ctl.exec_done) begin
          ph_nxt = fhs_pkg::FHS_RES;
        end
      end
      fhs_pkg::FHS_RES: begin
        if (ctl.result_last) begin
          ph_nxt  = fhs_pkg::FHS_IDLE;
          rqm_nxt = 1'b1;
        end
      end
      default: begin
        ph_nxt = fhs_pkg::FHS_INIT;
      end
    endcase
    if (soft_rst || fpd_nxt) begin
      ph_nxt   = fhs_pkg::FHS_INIT;
      init_nxt = 16'h0000;
      seek_nxt = 2'h0;
    end
    // Status image
    stat_nxt = `FHS_STATUS_ZERO;
    unique case (ph_nxt)
      fhs_pkg::FHS_INIT: stat_nxt = `FHS_STATUS_ZERO;
      fhs_pkg::FHS_IDLE: stat_nxt = {rqm_nxt, 5'h00, seek_nxt};
      fhs_pkg::FHS_CMD:  stat_nxt = {rqm_nxt, 3'h1, 2'h0, seek_nxt};
      fhs_pkg::FHS_EXEC: begin
        if (ctl.polled_execution_flag) begin
          stat_nxt = {ctl.irq, ctl.exec_read, 2'h3, 2'h0, seek_nxt};
        end else begin
          stat_nxt = {1'b1, 3'h1, 2'h0, seek_nxt};
        end
      end
      fhs_pkg::FHS_RES: stat_nxt = {rqm_nxt, ctl.polled_execution_flag, 2'h1, 2'h0, seek_nxt};
      default: stat_nxt = `FHS_STATUS_ZERO;
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ph_r            <= fhs_pkg::FHS_INIT;
      init_r          <= 16'h0000;
      rqm_r           <= 1'b1;
      seek_r          <= 2'h0;
      main_status_reg <= `FHS_STATUS_ZERO;
    end else begin
      ph_r            <= ph_nxt;
      init_r          <= init_nxt;
      rqm_r           <= rqm_nxt;
      seek_r          <= seek_nxt;
      main_status_reg <= stat_nxt;
    end
  end

  assign io_rdata = (sel && io_rd) ? main_status_reg : `FHS_STATUS_ZERO;

  // ****************************************
  // Checks
  // ****************************************
  logic [15:0] zero_run_r;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      zero_run_r <= 16'h0000;
    end else if (ph_r == fhs_pkg::FHS_INIT && !fpd_r && !soft_rst) begin
      zero_run_r <= zero_run_r + 16'h0001;
    end else begin
      zero_run_r <= 16'h0000;
    end
  end

  init_bound_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    zero_run_r <= 16'(INIT_CYCLES)) else $error("status stuck at zero too long");
  init_zero_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ph_r == fhs_pkg::FHS_INIT |-> main_status_reg == `FHS_STATUS_ZERO)
    else $error("status not zero while initialising");
  idle_ready_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ph_r == fhs_pkg::FHS_IDLE && seek_r == 2'h0 |-> main_status_reg == 8'h80)
    else $error("idle status not 80h");
  reserved_zero_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    main_status_reg[3:2] == 2'h0) else $error("status bits 3:2 not zero");
  xfer_clear_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ctl.fifo_xfer && !ctl.byte_ready && ph_r == fhs_pkg::FHS_CMD && !soft_rst
    && !ctl.cmd_done |=> !main_status_reg[7]) else $error("request bit not cleared");
  swrst_pulse_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    wr_hit && io_wdata[`FHS_RS_SWRST] |=> module_soft_reset ##1 !module_soft_reset || soft_rst)
    else $error("soft reset not self clearing");
  keep_rate_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ctl.dor_reset && !wr_hit |=> $stable(data_rate_field) && $stable(write_field_a)
    && $stable(oscillator_powerdown)) else $error("soft reset disturbed settings");
  fpd_hold_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    wr_hit && io_wdata[`FHS_RS_FPD] |=> direct_powerdown ##1 main_status_reg == 8'h00)
    else $error("direct powerdown not entered");
  restore_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !oscillator_powerdown && !wr_hit |=> !oscillator_powerdown)
    else $error("oscillator powerdown set without host write");
  busy_cmd_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ph_r == fhs_pkg::FHS_CMD |-> main_status_reg[4] && !main_status_reg[6])
    else $error("command phase status wrong");

endmodule

// ==== rtl/fhs_consts.svh ====
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 250 MHz sys_clk
// Notes:   Included by the status and rate-select block
`ifndef FHS_CONSTS_SVH
`define FHS_CONSTS_SVH
// ****************************************
// Register map
// ****************************************
`define FHS_OFS_STATUS_RATE 4'h4
`define FHS_RATE_RESET      8'h02
`define FHS_STATUS_ZERO     8'h00
// ****************************************
// Rate-select fields
// ****************************************
`define FHS_RS_SWRST        7
`define FHS_RS_FPD          6
`define FHS_RS_OSCILLATOR_POWERDOWN        5
`define FHS_RS_PRE_HI       4
`define FHS_RS_PRE_LO       2
`define FHS_RS_RATE_HI      1
`define FHS_RS_RATE_LO      0
`define FHS_WRITE_FIELD_A_DEFAULT 3'h0
// ****************************************
// Timing
// ****************************************
`define FHS_CLK_PERIOD_PS   4000
`define FHS_INIT_MAX_PS     2500000
`define FHS_INIT_CYCLES     (`FHS_INIT_MAX_PS / `FHS_CLK_PERIOD_PS)
`define FHS_BIT_500K        10'h1F4
`define FHS_BIT_300K        10'h341
`define FHS_BIT_250K        10'h3E8
`define FHS_BIT_1M          10'h0FA
`endif

// ==== rtl/fhs_pkg.sv ====
// Purpose: Types shared by the status and rate-select block
// Assumes: Nothing
// Notes:   Controller events travel as one packed struct
package fhs_pkg;
  typedef enum logic [4:0] {
    FHS_INIT = 5'h01,
    FHS_IDLE = 5'h02,
    FHS_CMD  = 5'h04,
    FHS_EXEC = 5'h08,
    FHS_RES  = 5'h10
  } fhs_phase_t;

  typedef struct packed {
    logic fifo_xfer;
    logic byte_ready;
    logic cmd_done;
    logic no_result;
    logic seek_cmd;
    logic cmd_drive;
    logic exec_done;
    logic exec_read;
    logic result_last;
    logic sense_first;
    logic sense_drive;
    logic polled_execution_flag;
    logic irq;
    logic dor_reset;
    logic restore_wr;
    logic restore_oscillator_powerdown;
  } fhs_ctl_t;
endpackage

// ==== bench/fhs_host_model.sv ====
// Purpose: Host processor model for the shared status and rate port
// Assumes: Single-byte I/O cycles, one at a time
// Notes:   Signals change only just after a rising edge
`timescale 1ns/1ps

module fhs_host_model (
  // Clock
  input  wire logic       sys_clk,
  // Host I/O port
  output logic      [3:0] io_addr,
  output logic            io_rd,
  output logic            io_wr,
  output logic      [7:0] io_wdata
);
  initial begin
    io_addr  = 4'h0;
    io_rd    = 1'b0;
    io_wr    = 1'b0;
    io_wdata = 8'h00;
  end
  // ****************************************
  // Host cycles
  // ****************************************
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    io_addr  <= a;
    io_wdata <= d;
    io_wr    <= 1'b1;
    @(posedge sys_clk);
    io_wr    <= 1'b0;
    io_wdata <= ~d;
  endtask
  // Status poll before each byte move
  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk);
    io_addr <= a;
    io_rd   <= 1'b1;
    @(posedge sys_clk);
    io_rd   <= 1'b0;
  endtask
endmodule

// ==== bench/floppy_host_status_rate_select_test.sv ====
// Purpose: Self-checking bench for the status and rate-select block
// Assumes: Small settle count, 250 MHz clock
// Notes:   Reads are checked against queued notes
`timescale 1ns/1ps

module floppy_host_status_rate_select_test;
  localparam int INIT = 8;
  localparam logic [15:0] GAP [4] = '{16'h01F4, 16'h0341, 16'h03E8, 16'h00FA};
  typedef struct packed {
    logic [7:0] st;
    logic [7:0] mask;
    logic [7:0] set;
  } fhs_note_t;
  logic              sys_clk;
  logic              reset_n;
  logic [3:0]        io_addr;
  logic              io_rd;
  logic              io_wr;
  logic [7:0]        io_wdata;
  logic [7:0]        io_rdata;
  fhs_pkg::fhs_ctl_t ctl;
  fhs_pkg::fhs_ctl_t lv;
  logic [1:0]        data_rate_field;
  logic [2:0]        write_field_a;
  logic              oscillator_powerdown;
  logic              osc_enable;
  logic              direct_powerdown;
  logic              module_soft_reset;
  logic              rate_tick;
  logic              gap_ok = 1'b0;
  logic [1:0]        last_rate = 2'h2;
  logic [15:0]       gap_cnt = 16'h0000;
  logic [15:0]       srst_cnt = 16'h0000;
  int                gap_checks = 0;
  logic              e_fpd;
  logic              e_osc;
  logic [2:0]        e_pre;
  logic [1:0]        e_rate;
  fhs_note_t         q[$];
  fhs_note_t         n;
  int                fail_count = 0;
  int                total_checks = 0;
  integer            seed;

  fhs_status_rate #(.INIT_CYCLES(INIT)) dut (
    .sys_clk (sys_clk), .reset_n (reset_n), .io_addr (io_addr), .io_rd (io_rd),
    .io_wr (io_wr), .io_wdata (io_wdata), .io_rdata (io_rdata), .ctl (ctl),
    .main_status_reg (), .data_rate_field (data_rate_field),
    .write_field_a (write_field_a), .oscillator_powerdown (oscillator_powerdown),
    .osc_enable (osc_enable), .direct_powerdown (direct_powerdown),
    .module_soft_reset (module_soft_reset), .rate_tick (rate_tick)
  );
  fhs_host_model host (
    .sys_clk (sys_clk), .io_addr (io_addr), .io_rd (io_rd), .io_wr (io_wr),
    .io_wdata (io_wdata)
  );
  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] st, input logic [7:0] m);
    q.push_back('{st, m, {e_fpd, ~e_osc, e_osc, e_pre, e_rate}});
    host.rd(a);
  endtask
  task automatic ev(input fhs_pkg::fhs_ctl_t c);
    @(posedge sys_clk);
    ctl <= fhs_pkg::fhs_ctl_t'(lv | c);
    @(posedge sys_clk);
    ctl <= lv;
  endtask
  task automatic settle();
    repeat (INIT + 4) @(posedge sys_clk);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ****************************************
  // Clock, monitor, watchdog
  // ****************************************
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (io_rd === 1'b1 && q.size() > 0) begin
      n = q.pop_front();
      chk("status", io_rdata & n.mask, n.st & n.mask);
      chk("settings", {direct_powerdown, osc_enable, oscillator_powerdown,
          write_field_a, data_rate_field}, n.set);
    end
    if (module_soft_reset === 1'b1) begin
      srst_cnt <= srst_cnt + 16'h0001;
    end
    last_rate <= data_rate_field;
    gap_cnt   <= gap_cnt + 16'h0001;
    if (reset_n !== 1'b1 || data_rate_field !== last_rate) begin
      gap_ok <= 1'b0;
    end
    if (rate_tick === 1'b1) begin
      if (gap_ok && data_rate_field === last_rate) begin
        gap_checks++;
        chk("tick gap", gap_cnt, GAP[data_rate_field]);
      end
      gap_cnt <= 16'h0001;
      gap_ok  <= 1'b1;
    end
  end
  // Tests need under 9000 cycles, mostly three tick periods per rate
  initial begin
    repeat (12000) @(posedge sys_clk);
    fail_count++;
    end_sim();
  end
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    seed = 32'hc673a486;
    reset_n = 1'b0;
    ctl = '0;
    lv = '0;
    {e_fpd, e_osc, e_pre, e_rate} = 7'h02;
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    rd(4'h4, 8'h00, 8'hFF);
    settle();
    rd(4'h4, 8'h80, 8'hFF);
    $display("test reset done");
    ev('{fifo_xfer: 1'b1, default: 1'b0});
    rd(4'h4, 8'h10, 8'hFF);
    ev('{byte_ready: 1'b1, default: 1'b0});
    rd(4'h4, 8'h90, 8'hFF);
    ev('{cmd_done: 1'b1, default: 1'b0});
    rd(4'h4, 8'h90, 8'hFF);
    ev('{exec_done: 1'b1, default: 1'b0});
    ev('{byte_ready: 1'b1, default: 1'b0});
    rd(4'h4, 8'h90, 8'hFF);
    ev('{result_last: 1'b1, default: 1'b0});
    rd(4'h4, 8'h80, 8'hFF);
    lv.polled_execution_flag = 1'b1;
    lv.exec_read = 1'b1;
    ev('{fifo_xfer: 1'b1, default: 1'b0});
    ev('{cmd_done: 1'b1, default: 1'b0});
    rd(4'h4, 8'h30, 8'hBF);
    lv.irq = 1'b1;
    ev('{default: 1'b0});
    rd(4'h4, 8'hF0, 8'hFF);
    lv.irq = 1'b0;
    ev('{exec_done: 1'b1, default: 1'b0});
    ev('{byte_ready: 1'b1, default: 1'b0});
    rd(4'h4, 8'hD0, 8'hFF);
    lv = '0;
    ev('{result_last: 1'b1, default: 1'b0});
    rd(4'h4, 8'h00, 8'h70);
    $display("test command phases done");
    ev('{fifo_xfer: 1'b1, default: 1'b0});
    ev('{cmd_done: 1'b1, no_result: 1'b1, seek_cmd: 1'b1, cmd_drive: 1'b1, default: 1'b0});
    rd(4'h4, 8'h02, 8'h1F);
    ev('{fifo_xfer: 1'b1, default: 1'b0});
    ev('{cmd_done: 1'b1, no_result: 1'b1, seek_cmd: 1'b1, default: 1'b0});
    rd(4'h4, 8'h03, 8'h1F);
    ev('{sense_first: 1'b1, sense_drive: 1'b1, default: 1'b0});
    rd(4'h4, 8'h01, 8'h0F);
    ev('{sense_first: 1'b1, default: 1'b0});
    rd(4'h4, 8'h00, 8'h0F);
    $display("test seek done");
    host.wr(4'h4, 8'h17);
    {e_pre, e_rate} = 5'h17;
    host.wr(4'h5, 8'hFF);
    rd(4'h5, 8'h00, 8'hFF);
    host.wr(4'h4, 8'h57);
    e_fpd = 1'b1;
    settle();
    rd(4'h4, 8'h00, 8'hFF);
    // Oscillator off stays set through the DOR reset that ends powerdown, until a restore clears it
    host.wr(4'h4, 8'h77);
    e_osc = 1'b1;
    rd(4'h4, 8'h00, 8'hFF);
    ev('{dor_reset: 1'b1, default: 1'b0});
    e_fpd = 1'b0;
    settle();
    rd(4'h4, 8'h80, 8'hFF);
    ev('{restore_wr: 1'b1, restore_oscillator_powerdown: 1'b1, default: 1'b0});
    rd(4'h4, 8'h80, 8'h80);
    ev('{restore_wr: 1'b1, default: 1'b0});
    e_osc = 1'b0;
    rd(4'h4, 8'h80, 8'h80);
    host.wr(4'h4, 8'h97);
    rd(4'h4, 8'h00, 8'hFF);
    settle();
    rd(4'h4, 8'h80, 8'hFF);
    chk("soft reset pulses", srst_cnt, 16'h0002);
    $display("test rate select done");
    host.wr(4'h4, 8'h57);
    host.wr(4'h4, 8'h77);
    @(posedge sys_clk);
    reset_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    {e_fpd, e_osc, e_pre, e_rate} = 7'h02;
    rd(4'h4, 8'h00, 8'hFF);
    settle();
    for (int i = 0; i < 4; i++) begin
      e_pre = 3'($random(seed));
      e_rate = 2'(i);
      host.wr(4'h4, {3'h0, e_pre, e_rate});
      repeat (3) @(posedge rate_tick);
      rd(4'h4, 8'h80, 8'h80);
    end
    chk("tick gaps seen", 16'(gap_checks >= 4), 16'h0001);
    $display("test hardware reset and rates done");
    @(posedge sys_clk);
    #1;
    end_sim();
  end
endmodule
